// file: common/adc_cfg_pkg.sv
/*
 Constants, register map and carrier types for the converter configuration bank.
 Assumes a serial host running frames of an 8-bit address word and a 16-bit data word.
*/
// Operation
// - bit 15 of reg 0 picks shared data pin or separate read-out pin.
// - bit 14 of reg 0 passes only every second sample, halving output rate.
// - with decimation off every converted sample is output at full rate.
// - bit 12 of reg 0 picks low or high pass, effective only with decimation.
// - bit 15 of reg 1 turns interleaving correction on; resets to 0.
// - bit 3 of reg 1 selects two's complement or offset binary output.
// - overload flag follows the overload condition by exactly 12 clocks.
// - reg 2 bits 10..7 set the overload trip level in sixteenths of full scale.
// - after any reset the trip level field holds 15.
// - bit 14 of reg 3 resets to 1; writing 0 starts the trim loop.
// - one write updates every field of the addressed register together.
// - each frame is an 8-bit address word then a 16-bit data word.
// - address bit 7 set means read, clear means write; bits 6..0 select register.
// - writing reg 0x2C restores all defaults, and that register reads 0.
package adc_cfg_pkg;

	// ==========================================================
	// frame layout
	localparam int ADDR_BITS = 8;
	localparam int DATA_BITS = 16;
	localparam int BIT_RW    = 7;
	localparam int SAMPLE_W  = 12;
	localparam int TEMP_W    = 9;
	localparam int OVR_LATENCY = 12;

	// ==========================================================
	// register offsets
	localparam int NUM_RW = 10;
	localparam logic [6:0] OFS_TEMP       = 7'h2B;
	localparam logic [6:0] OFS_SOFT_RESET = 7'h2C;
	localparam logic [6:0] RW_OFS [NUM_RW] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h0E,
		7'h0F, 7'h37, 7'h38, 7'h3A, 7'h66};
	localparam logic [15:0] RW_MASK [NUM_RW] = '{16'hD000, 16'h800A, 16'h0780, 16'h4000,
		16'hFFFC, 16'hF070, 16'hC000, 16'hFFF0, 16'hFFFF, 16'hFFFF};
	localparam logic [15:0] RW_FIXED1 [NUM_RW] = '{16'h0000, 16'h0000, 16'h0000, 16'h0B18,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
	localparam logic [15:0] RW_RESET [NUM_RW] = '{16'h0000, 16'h0000, 16'h0780, 16'h4B18,
		16'hAAA8, 16'hA000, 16'h0000, 16'hFFF0, 16'h0000, 16'h0000};
	localparam int IDX_PORT   = 0;
	localparam int IDX_CORR   = 1;
	localparam int IDX_OVR    = 2;
	localparam int IDX_TRIM   = 3;
	localparam int IDX_ALIGNA = 4;
	localparam int IDX_ALIGNB = 5;
	localparam int IDX_LOWPWR = 6;
	localparam int IDX_BIAS   = 7;
	localparam int IDX_DRIVER = 8;
	localparam int IDX_BUSEN  = 9;

	// ==========================================================
	// field positions
	localparam int BIT_FOUR_WIRE  = 15;
	localparam int BIT_DECIM_EN   = 14;
	localparam int BIT_BAND_SEL   = 12;
	localparam int BIT_FIX_ON     = 15;
	localparam int BIT_OFFSET_BIN = 3;
	localparam int BIT_PERF_ONE   = 1;
	localparam int THR_LSB        = 7;
	localparam int THR_MSB        = 10;
	localparam int BIT_TRIM_KICK  = 14;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		SER_IDLE = 2'b00,
		SER_ADDR = 2'b01,
		SER_DATA = 2'b10,
		SER_DONE = 2'b11
	} serial_state_type;

	typedef struct packed {
		logic        four_wire;
		logic        decim_en;
		logic        filter_band_select;
		logic        interleave_fix_on;
		logic        offset_binary;
		logic        perf_tuning_bit_one;
		logic [3:0]  ovr_threshold;
		logic        trim_loop_kick;
		logic [15:0] align_source_a;
		logic [15:0] align_source_and_reference;
		logic [15:0] low_power_select;
		logic [15:0] bias_and_input_buffer_ctrl;
		logic [15:0] output_driver_ctrl;
		logic [15:0] output_bus_enable;
	} cfg_type;

endpackage

// file: rtl/adc_config_register_bank.sv
/*
 Serial-programmed configuration bank plus the small datapath it steers:
 decimation gate, output coding and delayed overload flag.
 Assumes serial pins far slower than core_clk_i (at most one quarter of its rate)
 and samples arriving on core_clk_i.
*/
`timescale 1ns/1ps
module adc_config_register_bank
	import adc_cfg_pkg::*;
(
	input  wire logic                core_clk_i,                 // 40 MHz core clock
	input  wire logic                rst_n_i,                    // async reset, active low
	input  wire logic                sclk_i,                     // serial clock pin
	input  wire logic                serial_select_n_i,          // frame select pin, low active
	input  wire logic                sdio_i,                     // data pin input
	output logic                     sdio_o,                     // data pin output value
	output logic                     sdio_oe_n_o,                // data pin enable, low drives
	output logic                     serial_read_out_pin_o,      // read-out pin value
	output logic                     serial_read_out_pin_oe_n_o, // read-out enable, low drives
	input  wire logic [TEMP_W-1:0]   temp_code_i,                // temperature sensor code
	input  wire logic                sample_valid_i,             // converted sample strobe
	input  wire logic [SAMPLE_W-1:0] sample_data_i,              // two's complement sample
	output logic                     out_valid_o,                // output sample strobe
	output logic [SAMPLE_W-1:0]      out_data_o,                 // output sample word
	output logic                     overload_flag_o,            // delayed overload flag
	output cfg_type                  cfg_o                       // decoded configuration
);

	// ==========================================================
	// pin synchronisers: sclk, select, data in
	logic [2:0] pin_meta_reg, pin_meta_next;
	logic [2:0] pin_sync_reg, pin_sync_next;
	logic [2:0] pin_dly_reg,  pin_dly_next;

	always_comb
	begin
		pin_meta_next = {sdio_i, serial_select_n_i, sclk_i};
		pin_sync_next = pin_meta_reg;
		pin_dly_next  = pin_sync_reg;
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pin_meta_reg <= 3'h6;
			pin_sync_reg <= 3'h6;
			pin_dly_reg  <= 3'h6;
		end
		else
		begin
			pin_meta_reg <= pin_meta_next;
			pin_sync_reg <= pin_sync_next;
			pin_dly_reg  <= pin_dly_next;
		end
	end

	logic sclk_rise, sclk_fall, sel_n, sdi;
	assign sclk_rise = pin_sync_reg[0] & ~pin_dly_reg[0];
	assign sclk_fall = ~pin_sync_reg[0] & pin_dly_reg[0];
	assign sel_n     = pin_sync_reg[1];
	assign sdi       = pin_sync_reg[2];

	// ==========================================================
	// register storage
	logic [15:0] bank_reg [NUM_RW], bank_next [NUM_RW];
	logic        commit_stb_reg;
	logic [6:0]  commit_addr_reg;
	logic [15:0] commit_data_reg;
	logic        soft_reset;

	assign soft_reset = commit_stb_reg && (commit_addr_reg == OFS_SOFT_RESET);
	genvar gi;
	generate
		for (gi = 0; gi < NUM_RW; gi++)
		begin : g_bank
			always_comb
			begin
				bank_next[gi] = bank_reg[gi];
				if (soft_reset)
					bank_next[gi] = RW_RESET[gi];
				else if (commit_stb_reg && (commit_addr_reg == RW_OFS[gi]))
					bank_next[gi] = (commit_data_reg & RW_MASK[gi]) | RW_FIXED1[gi];
			end
			always_ff @(posedge core_clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
					bank_reg[gi] <= RW_RESET[gi];
				else
					bank_reg[gi] <= bank_next[gi];
			end
			fixed_bits_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
				(bank_reg[gi] & ~RW_MASK[gi]) == RW_FIXED1[gi])
				else $error("fixed register bits changed");
			write_only_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
				!commit_stb_reg |=> $stable(bank_reg[gi]))
				else $error("register changed without a write");
		end
	endgenerate

	// ==========================================================
	// configuration decode
	always_comb
	begin
		cfg_o                            = '0;
		cfg_o.four_wire                  = bank_reg[IDX_PORT][BIT_FOUR_WIRE];
		cfg_o.decim_en                   = bank_reg[IDX_PORT][BIT_DECIM_EN];
		// the band bit means nothing until the filter is in the path
		cfg_o.filter_band_select         = bank_reg[IDX_PORT][BIT_BAND_SEL]
			& bank_reg[IDX_PORT][BIT_DECIM_EN];
		cfg_o.interleave_fix_on          = bank_reg[IDX_CORR][BIT_FIX_ON];
		cfg_o.offset_binary              = bank_reg[IDX_CORR][BIT_OFFSET_BIN];
		cfg_o.perf_tuning_bit_one        = bank_reg[IDX_CORR][BIT_PERF_ONE];
		cfg_o.ovr_threshold              = bank_reg[IDX_OVR][THR_MSB:THR_LSB];
		cfg_o.trim_loop_kick             = bank_reg[IDX_TRIM][BIT_TRIM_KICK];
		cfg_o.align_source_a             = bank_reg[IDX_ALIGNA];
		cfg_o.align_source_and_reference = bank_reg[IDX_ALIGNB];
		cfg_o.low_power_select           = bank_reg[IDX_LOWPWR];
		cfg_o.bias_and_input_buffer_ctrl = bank_reg[IDX_BIAS];
		cfg_o.output_driver_ctrl         = bank_reg[IDX_DRIVER];
		cfg_o.output_bus_enable          = bank_reg[IDX_BUSEN];
	end

	// ==========================================================
	// serial frame engine
	serial_state_type state_reg, state_next;
	logic [3:0]  cnt_reg, cnt_next;
	logic [15:0] shift_in_reg, shift_in_next;
	logic [6:0]  addr_reg, addr_next;
	logic        rw_reg, rw_next;
	logic        load_pend_reg, load_pend_next;
	logic [15:0] out_shift_reg, out_shift_next;
	logic        drive_reg, drive_next;
	logic        commit_stb_next;
	logic [6:0]  commit_addr_next;
	logic [15:0] commit_data_next;
	logic [15:0] rd_word;
	always_comb
	begin
		rd_word = 16'h0000; // unmapped and soft reset read as zero
		if (addr_reg == OFS_TEMP)
			rd_word = {{(DATA_BITS - TEMP_W){1'b0}}, temp_code_i};
		for (int i = 0; i < NUM_RW; i++)
			if (addr_reg == RW_OFS[i])
				rd_word = bank_reg[i];
	end
	always_comb
	begin
		state_next       = state_reg;
		cnt_next         = cnt_reg;
		shift_in_next    = shift_in_reg;
		addr_next        = addr_reg;
		rw_next          = rw_reg;
		load_pend_next   = load_pend_reg;
		out_shift_next   = out_shift_reg;
		drive_next       = drive_reg;
		commit_stb_next  = 1'b0;
		commit_addr_next = commit_addr_reg;
		commit_data_next = commit_data_reg;
		if (sel_n)
		begin
			// a frame cut short by the select rising is dropped whole
			state_next     = SER_IDLE;
			drive_next     = 1'b0;
			load_pend_next = 1'b0;
		end
		else
		begin
			case (state_reg)
				SER_IDLE:
				begin
					state_next = SER_ADDR;
					cnt_next   = 4'h0;
				end
				SER_ADDR:
					if (sclk_rise)
					begin
						shift_in_next = {shift_in_reg[14:0], sdi};
						cnt_next      = cnt_reg + 4'h1;
						if (cnt_reg == 4'(ADDR_BITS - 1))
						begin
							rw_next        = shift_in_reg[BIT_RW - 1];
							addr_next      = {shift_in_reg[5:0], sdi};
							load_pend_next = shift_in_reg[BIT_RW - 1];
							cnt_next       = 4'h0;
							state_next     = SER_DATA;
						end
					end
				SER_DATA:
				begin
					if (sclk_fall && rw_reg)
					begin
						if (load_pend_reg)
						begin
							out_shift_next = rd_word;
							load_pend_next = 1'b0;
							drive_next     = 1'b1;
						end
						else
							out_shift_next = {out_shift_reg[14:0], 1'b0};
					end
					if (sclk_rise)
					begin
						shift_in_next = {shift_in_reg[14:0], sdi};
						cnt_next      = cnt_reg + 4'h1;
						if (cnt_reg == 4'(DATA_BITS - 1))
						begin
							state_next       = SER_DONE;
							commit_stb_next  = !rw_reg;
							commit_addr_next = addr_reg;
							commit_data_next = {shift_in_reg[14:0], sdi};
						end
					end
				end
				SER_DONE:
					state_next = SER_DONE;
				default:
					state_next = SER_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_reg       <= SER_IDLE;
			cnt_reg         <= 4'h0;
			shift_in_reg    <= 16'h0000;
			addr_reg        <= 7'h00;
			rw_reg          <= 1'b0;
			load_pend_reg   <= 1'b0;
			out_shift_reg   <= 16'h0000;
			drive_reg       <= 1'b0;
			commit_stb_reg  <= 1'b0;
			commit_addr_reg <= 7'h00;
			commit_data_reg <= 16'h0000;
		end
		else
		begin
			state_reg       <= state_next;
			cnt_reg         <= cnt_next;
			shift_in_reg    <= shift_in_next;
			addr_reg        <= addr_next;
			rw_reg          <= rw_next;
			load_pend_reg   <= load_pend_next;
			out_shift_reg   <= out_shift_next;
			drive_reg       <= drive_next;
			commit_stb_reg  <= commit_stb_next;
			commit_addr_reg <= commit_addr_next;
			commit_data_reg <= commit_data_next;
		end
	end

	assign sdio_o                     = out_shift_reg[15];
	assign serial_read_out_pin_o      = out_shift_reg[15];
	assign sdio_oe_n_o                = !(drive_reg && !cfg_o.four_wire);
	assign serial_read_out_pin_oe_n_o = !(drive_reg && cfg_o.four_wire);

	// ==========================================================
	// sample path: decimation gate, coding, overload delay
	logic                   phase_reg, phase_next;
	logic                   out_valid_reg, out_valid_next;
	logic [SAMPLE_W-1:0]    out_data_reg, out_data_next;
	logic [OVR_LATENCY-1:0] ovr_pipe_reg, ovr_pipe_next;
	logic [SAMPLE_W-2:0]    magnitude;
	logic                   ovr_cond;
	always_comb
	begin
		// one's complement magnitude keeps the compare free of an adder
		magnitude = sample_data_i[SAMPLE_W-1] ? ~sample_data_i[SAMPLE_W-2:0]
			: sample_data_i[SAMPLE_W-2:0];
		ovr_cond  = sample_valid_i
			&& (magnitude[SAMPLE_W-2 -: 4] >= cfg_o.ovr_threshold);
		ovr_pipe_next  = {ovr_pipe_reg[OVR_LATENCY-2:0], ovr_cond};
		phase_next     = cfg_o.decim_en ? (phase_reg ^ sample_valid_i) : 1'b0;
		out_valid_next = sample_valid_i && (!cfg_o.decim_en || phase_reg);
		out_data_next  = out_data_reg;
		if (out_valid_next)
			out_data_next = {sample_data_i[SAMPLE_W-1] ^ cfg_o.offset_binary,
				sample_data_i[SAMPLE_W-2:0]};
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			phase_reg     <= 1'b0;
			out_valid_reg <= 1'b0;
			out_data_reg  <= '0;
			ovr_pipe_reg  <= '0;
		end
		else
		begin
			phase_reg     <= phase_next;
			out_valid_reg <= out_valid_next;
			out_data_reg  <= out_data_next;
			ovr_pipe_reg  <= ovr_pipe_next;
		end
	end

	assign out_valid_o     = out_valid_reg;
	assign out_data_o      = out_data_reg;
	assign overload_flag_o = ovr_pipe_reg[OVR_LATENCY-1];

	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	ovr_delay_a: assert property (ovr_cond |-> ##12 overload_flag_o)
		else $error("overload flag not raised 12 clocks after condition");
	ovr_quiet_a: assert property (!ovr_cond |-> ##12 !overload_flag_o)
		else $error("overload flag without condition");
	full_rate_a: assert property (!cfg_o.decim_en && sample_valid_i |=> out_valid_o)
		else $error("sample dropped at full rate");
	decim_skip_a: assert property (cfg_o.decim_en && sample_valid_i && !phase_reg
		|=> !out_valid_o)
		else $error("decimation passed a skipped sample");
	soft_reset_a: assert property (soft_reset |=> cfg_o.ovr_threshold == 4'hF
		&& cfg_o.trim_loop_kick && !cfg_o.decim_en)
		else $error("soft reset did not restore defaults");
	thr_write_a: assert property (commit_stb_reg && commit_addr_reg == RW_OFS[IDX_OVR]
		|=> cfg_o.ovr_threshold == $past(commit_data_reg[THR_MSB:THR_LSB]))
		else $error("threshold write not applied");
	pin_choice_a: assert property (!sdio_oe_n_o |-> !cfg_o.four_wire && rw_reg
		&& !serial_read_out_pin_oe_n_o == 1'b0)
		else $error("wrong pin driven for read data");
	addr_done_a: assert property (state_reg == SER_ADDR && !sel_n && sclk_rise
		&& cnt_reg == 4'h7 |=> state_reg == SER_DATA && cnt_reg == 4'h0)
		else $error("address word not closed after eight bits");

	write_c: cover property (commit_stb_reg && !soft_reset);
	read_c: cover property (drive_reg && $rose(drive_reg));
	reset_c: cover property (soft_reset);
	ovr_c: cover property ($rose(overload_flag_o));
	decim_c: cover property (cfg_o.decim_en && out_valid_o);
endmodule

// file: sim/serial_host_model.sv
/*
 Behavioural serial host for the converter configuration bank: frames of an
 8-bit address word and a 16-bit data word, shared or separate read-out pin.
 Assumes the bench calls frame() hierarchically, one frame at a time.
*/
`timescale 1ns/1ps
module serial_host_model (
	input  wire logic core_clk_i,        // core clock used for pacing
	input  wire logic sdio_out_i,        // device value on shared pin
	input  wire logic sdio_oe_n_i,       // device drive enable, shared pin
	input  wire logic read_out_i,        // device value on read-out pin
	input  wire logic read_out_oe_n_i,   // device drive enable, read-out pin
	output logic      sclk_o,            // serial clock, low outside frames
	output logic      serial_select_n_o, // frame select, low active
	output logic      sdio_wire_o        // resolved shared pin level
);
	// half period of six core cycles keeps the synced serial clock well under core/4
	localparam int HALF = 6;
	logic host_bit;
	logic host_drive;
	logic last_bit = 1'b0;
	logic four_wire;
	int   misuse;

	// ==========================================================
	// pin resolution
	// a released pin shows the inverse of its last level so stale data cannot pass
	always_comb
	begin
		if (!sdio_oe_n_i)
			sdio_wire_o = sdio_out_i;
		else if (host_drive)
			sdio_wire_o = host_bit;
		else
			sdio_wire_o = ~last_bit;
	end

	always @(posedge core_clk_i)
		last_bit <= sdio_wire_o;

	initial
	begin
		sclk_o = 1'b0;
		serial_select_n_o = 1'b1;
		host_drive = 1'b0;
		host_bit = 1'b0;
		four_wire = 1'b0;
		misuse = 0;
	end

	// ==========================================================
	// frame engine
	task automatic pace(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask

	// nbits below 24 cuts the frame short by raising select early
	task automatic frame(input logic rd, input logic [6:0] addr, input logic [15:0] wdata,
		input int nbits, output logic [15:0] rdata);
		logic [23:0] word;
		word = {rd, addr, wdata};
		rdata = 16'h0000;
		serial_select_n_o = 1'b0;
		pace(HALF);
		for (int i = 23; i >= 24 - nbits; i--)
		begin
			host_drive = (i > 15) || !rd || four_wire;
			host_bit = word[i];
			pace(HALF);
			if (rd && i <= 15)
			begin
				if (four_wire)
				begin
					rdata[i] = read_out_oe_n_i ? ~last_bit : read_out_i;
					if (read_out_oe_n_i !== 1'b0 || sdio_oe_n_i !== 1'b1)
						misuse++;
				end
				else
				begin
					rdata[i] = sdio_wire_o;
					if (sdio_oe_n_i !== 1'b0 || read_out_oe_n_i !== 1'b1)
						misuse++;
				end
			end
			sclk_o = 1'b1;
			pace(HALF);
			sclk_o = 1'b0;
		end
		pace(HALF);
		serial_select_n_o = 1'b1;
		host_drive = 1'b0;
		if (!rd && nbits == 24 && addr == 7'h00)
			four_wire = wdata[15];
		if (!rd && nbits == 24 && addr == 7'h2C)
			four_wire = 1'b0;
		pace(3 * HALF);
	endtask
endmodule

// file: sim/adc_config_register_bank_bench.sv
/*
 Self-checking bench for the converter configuration bank.
 Assumes the host model in serial_host_model.sv and the package constants.
*/
`timescale 1ns/1ps
module adc_config_register_bank_bench;
	import adc_cfg_pkg::*;
	logic                core_clk;
	logic                rst_n;
	logic                sclk;
	logic                select_n;
	logic                sdio_wire;
	logic                sdio_out;
	logic                sdio_oe_n;
	logic                ro_pin;
	logic                ro_oe_n;
	logic [TEMP_W-1:0]   temp_code;
	logic                s_valid;
	logic [SAMPLE_W-1:0] s_data;
	logic                o_valid;
	logic [SAMPLE_W-1:0] o_data;
	logic                ovr_flag;
	cfg_type             cfg;
	int                  fails;
	int                  total_checks;
	int                  cnt;

	// ==========================================================
	// instances
	adc_config_register_bank dut (
		.core_clk_i(core_clk), .rst_n_i(rst_n), .sclk_i(sclk), .serial_select_n_i(select_n),
		.sdio_i(sdio_wire), .sdio_o(sdio_out), .sdio_oe_n_o(sdio_oe_n),
		.serial_read_out_pin_o(ro_pin), .serial_read_out_pin_oe_n_o(ro_oe_n),
		.temp_code_i(temp_code), .sample_valid_i(s_valid), .sample_data_i(s_data),
		.out_valid_o(o_valid), .out_data_o(o_data), .overload_flag_o(ovr_flag), .cfg_o(cfg));

	serial_host_model host (
		.core_clk_i(core_clk), .sdio_out_i(sdio_out), .sdio_oe_n_i(sdio_oe_n),
		.read_out_i(ro_pin), .read_out_oe_n_i(ro_oe_n), .sclk_o(sclk),
		.serial_select_n_o(select_n), .sdio_wire_o(sdio_wire));

	always #12.5 core_clk = ~core_clk;

	// ==========================================================
	// helpers
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [6:0] addr, input logic [15:0] data);
		logic [15:0] r;
		host.frame(1'b0, addr, data, 24, r);
	endtask

	task automatic rd_chk(input logic [6:0] addr, input logic [15:0] exp);
		logic [15:0] r;
		host.frame(1'b1, addr, 16'h0000, 24, r);
		check(r, exp);
	endtask

	task automatic run_samples(input int n, input logic [11:0] d, output int c);
		c = 0;
		s_data = d;
		s_valid = 1'b1;
		repeat (n)
		begin
			tick(1);
			if (o_valid === 1'b1)
				c++;
		end
		s_valid = 1'b0;
		tick(1);
		if (o_valid === 1'b1)
			c++;
	endtask

	// returns the cycle count from the sample to the flag, 0 when it does not rise within 20 cycles
	task automatic ovr_probe(input logic [11:0] d, output int first);
		first = 0;
		s_data = d;
		s_valid = 1'b1;
		for (int k = 1; k <= 20; k++)
		begin
			tick(1);
			s_valid = 1'b0;
			if (first == 0 && ovr_flag === 1'b1)
				first = k;
		end
	endtask

	task automatic reset_table;
		for (int i = 0; i < NUM_RW; i++)
			rd_chk(RW_OFS[i], RW_RESET[i]);
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// a hang anywhere ends the run as a failure
	initial
	begin
		repeat (60000) @(posedge core_clk);
		fails++;
		final_report();
	end

	// ==========================================================
	// main sequence
	initial
	begin
		logic [15:0] r;
		core_clk = 1'b0;
		rst_n = 1'b0;
		temp_code = 9'h1A5;
		s_valid = 1'b0;
		s_data = 12'h000;
		fails = 0;
		total_checks = 0;
		tick(10);
		rst_n = 1'b1;
		tick(5);
		reset_table();
		check(16'(cfg.ovr_threshold), 16'h000F);
		check(16'(cfg.trim_loop_kick), 16'h0001);
		rd_chk(OFS_TEMP, 16'h01A5);
		wr(OFS_TEMP, 16'hFFFF);
		rd_chk(OFS_TEMP, 16'h01A5);
		rd_chk(7'h10, 16'h0000);
		run_samples(8, 12'h123, cnt);
		check(16'(cnt), 16'h0008);
		check(16'(o_data), 16'h0123);
		wr(7'h00, 16'h1000);
		check(16'(cfg.filter_band_select), 16'h0000);
		rd_chk(7'h00, 16'h1000);
		wr(7'h00, 16'h5000);
		check(16'({cfg.decim_en, cfg.filter_band_select}), 16'h0003);
		run_samples(8, 12'h123, cnt);
		check(16'(cnt), 16'h0004);
		wr(7'h00, 16'hFFFF);
		rd_chk(7'h00, 16'hD000);
		wr(7'h00, 16'h0000);
		run_samples(8, 12'h123, cnt);
		check(16'(cnt), 16'h0008);
		wr(7'h01, 16'hFFFF);
		rd_chk(7'h01, 16'h800A);
		check(16'({cfg.interleave_fix_on, cfg.offset_binary, cfg.perf_tuning_bit_one}),
			16'h0007);
		run_samples(2, 12'h123, cnt);
		check(16'(o_data), 16'h0923);
		host.frame(1'b0, 7'h01, 16'h0000, 12, r);
		rd_chk(7'h01, 16'h800A);
		wr(7'h03, 16'h0000);
		rd_chk(7'h03, 16'h0B18);
		check(16'(cfg.trim_loop_kick), 16'h0000);
		ovr_probe(12'h7FF, cnt);
		check(16'(cnt), 16'h000C);
		ovr_probe(12'h780, cnt);
		check(16'(cnt), 16'h000C);
		wr(7'h02, 16'h0400);
		rd_chk(7'h02, 16'h0400);
		check(16'(cfg.ovr_threshold), 16'h0008);
		ovr_probe(12'h400, cnt);
		check(16'(cnt), 16'h000C);
		ovr_probe(12'h3FF, cnt);
		check(16'(cnt), 16'h0000);
		wr(7'h00, 16'h8000);
		check(16'(cfg.four_wire), 16'h0001);
		rd_chk(7'h02, 16'h0400);
		rd_chk(7'h00, 16'h8000);
		wr(7'h3A, 16'h5A5A);
		check(cfg.output_driver_ctrl, 16'h5A5A);
		wr(7'h37, 16'hFFFF);
		check(cfg.low_power_select, 16'hC000);
		wr(7'h66, 16'h00FF);
		check(cfg.output_bus_enable, 16'h00FF);
		wr(OFS_SOFT_RESET, 16'h0001);
		reset_table();
		rd_chk(OFS_SOFT_RESET, 16'h0000);
		check(16'(cfg.ovr_threshold), 16'h000F);
		check(16'(cfg.four_wire), 16'h0000);
		check(cfg.align_source_a, RW_RESET[IDX_ALIGNA]);
		check(cfg.align_source_and_reference, RW_RESET[IDX_ALIGNB]);
		check(cfg.low_power_select, RW_RESET[IDX_LOWPWR]);
		check(cfg.bias_and_input_buffer_ctrl, RW_RESET[IDX_BIAS]);
		check(cfg.output_driver_ctrl, RW_RESET[IDX_DRIVER]);
		check(cfg.output_bus_enable, RW_RESET[IDX_BUSEN]);
		check(16'(host.misuse), 16'h0000);
		final_report();
	end
endmodule
